//--- rtl/tm2_capedge.v
`timescale 1ns/1ps
`include "tm2_defs.vh"

module tm2_capedge (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       pin_i,
    input  wire       en_i,
    input  wire [1:0] edge_i,
    output reg        evt_o
);
    reg pin_r;
    reg hit;

    // edge select, reserved code never fires
    always @* begin
        case (edge_i)
            `TM2_EDGE_FALL: hit = pin_r & ~pin_i;
            `TM2_EDGE_RISE: hit = ~pin_r & pin_i;
            `TM2_EDGE_BOTH: hit = pin_r ^ pin_i;
            default:        hit = 1'b0;
        endcase
    end

    // last pin level and one-cycle event pulse
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_r <= 1'b0;
            evt_o <= 1'b0;
        end else begin
            pin_r <= pin_i;
            evt_o <= en_i & hit;
        end
    end
endmodule

//--- rtl/tm2_presc.v
`timescale 1ns/1ps
`include "tm2_defs.vh"

module tm2_presc (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       run_i,
    input  wire [2:0] sel_i,
    output wire       tick_o
);
    reg  [8:0] div_r;
    wire [8:0] mask;

    // division 4 << sel: low bits of the counter all ones ends a period
    assign mask   = `TM2_DIV_MASK >> (`TM2_DIV_TOP - sel_i);
    assign tick_o = run_i & ((div_r & mask) == mask);

    // free divider, held at zero while halted
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_r <= 9'h000;
        end else if (!run_i) begin
            div_r <= 9'h000;
        end else if (tick_o) begin
            div_r <= 9'h000;
        end else begin
            div_r <= div_r + 9'h001;
        end
    end
endmodule

//--- rtl/tm2_top.v
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tm2_defs.vh"

// Functional notes
// - with reload enabled and compare mode off the pair is loaded into the counter on the trigger, else never.
// - counter ticks at the clock divided by 4 << prescale_select.
// - capture_autoclear clears the counter on a capture event, else counting goes on.
// - match_autoclear clears the counter on a compare match, else counting goes on.
// - reload trigger is overflow, or capture channel 0, 1 or 2 event by code.
// - the reload/compare pair is the compare value or the reload value by mode.
// - the counter is two separately readable and writable bytes.
// - compare_mode_select wins; else reload_enable picks auto-reload over capture.
// - reset clears mode, reload/compare and counter registers.
// - the counter advances only while run_control is set; when halted only capture clears, capture reloads and writes change it.
// - overflow or match sets overflow_match_flag, which only software clears.
// - an enabled capture edge copies the counter and sets that channel's flag.
module tm2_top #(
    parameter ADDR_W = 12,
    parameter NCAP   = 3
) (
    input  wire              clk_i,
    input  wire              rstn_i,
    input  wire [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire              s_axi_awvalid_i,
    output wire              s_axi_awready_o,
    input  wire [31:0]       s_axi_wdata_i,
    input  wire [3:0]        s_axi_wstrb_i,
    input  wire              s_axi_wvalid_i,
    output wire              s_axi_wready_o,
    output reg  [1:0]        s_axi_bresp_o,
    output reg               s_axi_bvalid_o,
    input  wire              s_axi_bready_i,
    input  wire [ADDR_W-1:0] s_axi_araddr_i,
    input  wire              s_axi_arvalid_i,
    output wire              s_axi_arready_o,
    output reg  [31:0]       s_axi_rdata_o,
    output reg  [1:0]        s_axi_rresp_o,
    output reg               s_axi_rvalid_o,
    input  wire              s_axi_rready_i,
    input  wire [NCAP-1:0]   cap_pin_i,
    output wire              irq_o
);
    // bus holding registers
    reg  [ADDR_W-1:0] awaddr_r;
    reg               aw_hold_r;
    reg  [31:0]       wdata_r;
    reg  [3:0]        wstrb_r;
    reg               w_hold_r;
    wire              do_wr;
    wire [7:0]        widx;
    wire [7:0]        ridx;
    wire              wlane0;
    reg  [31:0]       rd_mux;
    reg               rd_hit;
    reg               wr_hit;

    // software state
    reg               run_r;
    reg               cmp_mode_r;
    reg  [7:0]        mode_r;
    reg  [7:0]        rcl_r;
    reg  [7:0]        rch_r;
    reg  [15:0]       cnt_r;
    reg  [15:0]       cnt_nxt;
    reg  [NCAP-1:0]   cap_en_r;
    reg  [2*NCAP-1:0] cap_edge_r;
    reg  [NCAP:0]     stat_r;
    reg  [NCAP:0]     stat_nxt;
    reg  [NCAP:0]     mask_r;
    reg  [15:0]       cap_r [0:NCAP-1];

    // timer events
    wire              tick;
    wire [NCAP-1:0]   cap_evt;
    wire [15:0]       rc_val;
    wire              rld_en;
    wire              cap_clr;
    wire              cmp_clr;
    wire [1:0]        trig_sel;
    wire              ovf;
    wire              match;
    reg               trig;
    wire              reload;

    assign widx   = awaddr_r[9:2];
    assign ridx   = s_axi_araddr_i[9:2];
    assign wlane0 = wstrb_r[0];

    // write address and data taken in either order, answered when both held
    assign s_axi_awready_o = ~aw_hold_r & ~s_axi_bvalid_o;
    assign s_axi_wready_o  = ~w_hold_r & ~s_axi_bvalid_o;
    assign do_wr           = aw_hold_r & w_hold_r & ~s_axi_bvalid_o;
    assign s_axi_arready_o = ~s_axi_rvalid_o;

    // mode field decode
    assign rld_en   = mode_r[`TM2_MODE_RLDEN];
    assign cap_clr  = mode_r[`TM2_MODE_CAPCLR];
    assign cmp_clr  = mode_r[`TM2_MODE_CMPCLR];
    assign trig_sel = mode_r[`TM2_MODE_TRIG_HI:`TM2_MODE_TRIG_LO];
    assign rc_val   = {rch_r, rcl_r};

    tm2_presc u_presc (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .run_i  (run_r),
        .sel_i  (mode_r[`TM2_MODE_DIV_HI:`TM2_MODE_DIV_LO]),
        .tick_o (tick)
    );

    // capture edge detectors and result registers, one per channel
    genvar g;
    generate
        for (g = 0; g < NCAP; g = g + 1) begin : g_cap
            tm2_capedge u_edge (
                .clk_i  (clk_i),
                .rstn_i (rstn_i),
                .pin_i  (cap_pin_i[g]),
                .en_i   (cap_en_r[g]),
                .edge_i (cap_edge_r[2*g+1:2*g]),
                .evt_o  (cap_evt[g])
            );
            always @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cap_r[g] <= `TM2_RST_WORD;
                end else if (cap_evt[g]) begin
                    cap_r[g] <= cnt_r;
                end
            end
        end
    endgenerate

    // overflow and compare match qualified by the prescaler tick
    assign ovf   = tick & (cnt_r == 16'hFFFF);
    assign match = cmp_mode_r & tick & (cnt_r == rc_val);

    // reload trigger source
    always @* begin
        case (trig_sel)
            `TM2_TRIG_OVF:  trig = ovf;
            `TM2_TRIG_CAP0: trig = cap_evt[0];
            `TM2_TRIG_CAP1: trig = cap_evt[1];
            `TM2_TRIG_CAP2: trig = cap_evt[2];
            default:        trig = 1'b0;
        endcase
    end

    // reload only in auto-reload mode
    assign reload = rld_en & ~cmp_mode_r & trig;

    // counter next value, later lines take priority
    always @* begin
        cnt_nxt = cnt_r;
        if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
        if (match && cmp_clr) begin
            cnt_nxt = `TM2_RST_WORD;
        end
        if ((|cap_evt) && cap_clr) begin
            cnt_nxt = `TM2_RST_WORD;
        end
        if (reload) begin
            cnt_nxt = rc_val;
        end
        // byte writes win; racing a running count is unsafe, software halts first
        if (do_wr && wlane0 && widx == `TM2_IDX_CNTL) begin
            cnt_nxt[7:0] = wdata_r[7:0];
        end
        if (do_wr && wlane0 && widx == `TM2_IDX_CNTH) begin
            cnt_nxt[15:8] = wdata_r[7:0];
        end
    end

    // sticky status, a new event beats a write-one clear
    always @* begin
        stat_nxt = stat_r;
        if (do_wr && wlane0 && widx == `TM2_IDX_STAT) begin
            stat_nxt = stat_r & ~wdata_r[NCAP:0];
        end
        stat_nxt[`TM2_STAT_FLAG] = stat_nxt[`TM2_STAT_FLAG] | ovf | match;
        stat_nxt[NCAP:`TM2_STAT_CAP0] = stat_nxt[NCAP:`TM2_STAT_CAP0] | cap_evt;
    end

    // level interrupt from unmasked sticky bits
    assign irq_o = |(stat_r & mask_r);

    // timer state registers
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r  <= `TM2_RST_WORD;
            stat_r <= {(NCAP+1){1'b0}};
        end else begin
            cnt_r  <= cnt_nxt;
            stat_r <= stat_nxt;
        end
    end

    // software writable configuration
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_r      <= 1'b0;
            cmp_mode_r <= 1'b0;
            mode_r     <= `TM2_RST_BYTE;
            rcl_r      <= `TM2_RST_BYTE;
            rch_r      <= `TM2_RST_BYTE;
            cap_en_r   <= {NCAP{1'b0}};
            cap_edge_r <= {(2*NCAP){1'b0}};
            mask_r     <= {(NCAP+1){1'b0}};
        end else if (do_wr && wlane0) begin
            case (widx)
                `TM2_IDX_CTRL: begin
                    run_r      <= wdata_r[`TM2_CTRL_RUN];
                    cmp_mode_r <= wdata_r[`TM2_CTRL_CMP];
                end
                `TM2_IDX_MODE: mode_r <= wdata_r[7:0];
                `TM2_IDX_RCL:  rcl_r  <= wdata_r[7:0];
                `TM2_IDX_RCH:  rch_r  <= wdata_r[7:0];
                `TM2_IDX_CAPCFG: begin
                    cap_en_r <= wdata_r[NCAP-1:0];
                    cap_edge_r <= wdata_r[`TM2_CAPCFG_EDGE0+2*NCAP-1:`TM2_CAPCFG_EDGE0];
                end
                `TM2_IDX_MASK: mask_r <= wdata_r[NCAP:0];
                default: begin
                    mask_r <= mask_r;
                end
            endcase
        end
    end

    // write decode for the response
    always @* begin
        case (widx)
            `TM2_IDX_CTRL, `TM2_IDX_MODE, `TM2_IDX_RCL, `TM2_IDX_RCH,
            `TM2_IDX_CNTL, `TM2_IDX_CNTH, `TM2_IDX_CAPCFG,
            `TM2_IDX_STAT, `TM2_IDX_MASK,
            `TM2_IDX_CAP0, `TM2_IDX_CAP1, `TM2_IDX_CAP2: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write channel holding and response
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            awaddr_r       <= {ADDR_W{1'b0}};
            aw_hold_r      <= 1'b0;
            wdata_r        <= 32'h00000000;
            wstrb_r        <= 4'h0;
            w_hold_r       <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `TM2_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                awaddr_r  <= s_axi_awaddr_i;
                aw_hold_r <= 1'b1;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                wdata_r  <= s_axi_wdata_i;
                wstrb_r  <= s_axi_wstrb_i;
                w_hold_r <= 1'b1;
            end
            if (do_wr) begin
                aw_hold_r      <= 1'b0;
                w_hold_r       <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_hit ? `TM2_RESP_OKAY : `TM2_RESP_DECERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // read data mux, unused bits read as zero
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (ridx)
            `TM2_IDX_CTRL: begin
                rd_mux[`TM2_CTRL_FLAG] = stat_r[`TM2_STAT_FLAG];
                rd_mux[`TM2_CTRL_RUN]  = run_r;
                rd_mux[`TM2_CTRL_CMP]  = cmp_mode_r;
            end
            `TM2_IDX_MODE:   rd_mux[7:0]  = mode_r;
            `TM2_IDX_RCL:    rd_mux[7:0]  = rcl_r;
            `TM2_IDX_RCH:    rd_mux[7:0]  = rch_r;
            `TM2_IDX_CNTL:   rd_mux[7:0]  = cnt_r[7:0];
            `TM2_IDX_CNTH:   rd_mux[7:0]  = cnt_r[15:8];
            `TM2_IDX_CAPCFG: begin
                rd_mux[NCAP-1:0] = cap_en_r;
                rd_mux[`TM2_CAPCFG_EDGE0+2*NCAP-1:`TM2_CAPCFG_EDGE0] = cap_edge_r;
            end
            `TM2_IDX_STAT:   rd_mux[NCAP:0] = stat_r;
            `TM2_IDX_MASK:   rd_mux[NCAP:0] = mask_r;
            `TM2_IDX_CAP0:   rd_mux[15:0] = cap_r[0];
            `TM2_IDX_CAP1:   rd_mux[15:0] = cap_r[1];
            `TM2_IDX_CAP2:   rd_mux[15:0] = cap_r[2];
            default:         rd_hit = 1'b0;
        endcase
    end

    // read channel: one cycle from address to data
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h00000000;
            s_axi_rresp_o  <= `TM2_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_mux;
            s_axi_rresp_o  <= rd_hit ? `TM2_RESP_OKAY : `TM2_RESP_DECERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule

//--- shared/tm2_defs.vh
`ifndef TM2_DEFS_VH
`define TM2_DEFS_VH

// register indices, byte address is four times the index
`define TM2_IDX_CTRL      8'hC8
`define TM2_IDX_MODE      8'hC9
`define TM2_IDX_RCL       8'hCA
`define TM2_IDX_RCH       8'hCB
`define TM2_IDX_CNTL      8'hCC
`define TM2_IDX_CNTH      8'hCD
`define TM2_IDX_CAPCFG    8'hD0
`define TM2_IDX_STAT      8'hD1
`define TM2_IDX_MASK      8'hD2
`define TM2_IDX_CAP0      8'hD4
`define TM2_IDX_CAP1      8'hD5
`define TM2_IDX_CAP2      8'hD6

// reset values
`define TM2_RST_BYTE      8'h00
`define TM2_RST_WORD      16'h0000

// control register fields
`define TM2_CTRL_FLAG     7
`define TM2_CTRL_RUN      2
`define TM2_CTRL_CMP      0

// mode register fields
`define TM2_MODE_RLDEN    7
`define TM2_MODE_DIV_HI   6
`define TM2_MODE_DIV_LO   4
`define TM2_MODE_CAPCLR   3
`define TM2_MODE_CMPCLR   2
`define TM2_MODE_TRIG_HI  1
`define TM2_MODE_TRIG_LO  0

// reload trigger codes
`define TM2_TRIG_OVF      2'h0
`define TM2_TRIG_CAP0     2'h1
`define TM2_TRIG_CAP1     2'h2
`define TM2_TRIG_CAP2     2'h3

// capture edge codes
`define TM2_EDGE_FALL     2'h0
`define TM2_EDGE_RISE     2'h1
`define TM2_EDGE_BOTH     2'h2

// capture config: enables in [2:0], edge codes from bit 4, two bits each
`define TM2_CAPCFG_EDGE0  4

// status bits: 0 overflow/match flag, 1..3 capture flags
`define TM2_STAT_FLAG     0
`define TM2_STAT_CAP0     1

// bus responses
`define TM2_RESP_OKAY     2'h0
`define TM2_RESP_DECERR   2'h3

// prescaler counter mask at the widest division
`define TM2_DIV_MASK      9'h1FF
`define TM2_DIV_TOP       3'h7

`endif

//--- testbench/testbench.sv
`timescale 1ns/1ps
`include "tm2_defs.vh"

module testbench;
    logic        clk_i, rstn_i, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  wstrb;
    logic [2:0]  cap;
    logic [7:0]  regs [10] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0, 8'hD1,
                               8'hD2, 8'hD4};
    int          miscompares, samples_checked, div;

    tm2_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .cap_pin_i(cap), .irq_o(irq));

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    task automatic final_report;
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bus write, handshakes sampled mid-cycle, released after the edge
    task automatic wr(input logic [7:0] idx, input logic [31:0] dat,
                      input logic [1:0] er = `TM2_RESP_OKAY);
        logic at, wt, bv;
        logic [1:0] rs;
        @(posedge clk_i);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk_i);
            at = awvalid && awready;
            wt = wvalid && wready;
            bv = bvalid;
            rs = bresp;
            @(posedge clk_i);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end while (!bv);
        bready <= 1'b0;
        check("write response", 32'(rs), 32'(er));
    endtask

    // bus read, rready raised after lag cycles to let the answer wait
    task automatic rd(input logic [7:0] idx, output logic [31:0] dat, output logic [1:0] rs,
                      input int lag = 0);
        logic at, rv;
        @(posedge clk_i);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= (lag == 0);
        do begin
            @(negedge clk_i);
            at = arvalid && arready;
            rv = rvalid && rready;
            dat = rdata;
            rs = rresp;
            @(posedge clk_i);
            if (at) arvalid <= 1'b0;
            if (lag > 0) lag--;
            if (rv) rready <= 1'b0;
            else if (lag == 0) rready <= 1'b1;
        end while (!rv);
    endtask

    task automatic chk(input logic [7:0] idx, input logic [31:0] e, input string nm);
        logic [31:0] v;
        logic [1:0] rs;
        rd(idx, v, rs);
        check(nm, v, e);
    endtask

    task automatic cnt_is(input logic [15:0] e);
        logic [31:0] lo, hi;
        logic [1:0] rs;
        rd(`TM2_IDX_CNTL, lo, rs);
        rd(`TM2_IDX_CNTH, hi, rs);
        check("counter", {hi[23:0], lo[7:0]}, {16'h0000, e});
    endtask

    task automatic setup(input logic [7:0] mode, input logic [15:0] pair, input logic [15:0] c);
        wr(`TM2_IDX_CTRL, 32'h0);
        wr(`TM2_IDX_RCL, 32'(pair[7:0]));
        wr(`TM2_IDX_RCH, 32'(pair[15:8]));
        wr(`TM2_IDX_CNTL, 32'(c[7:0]));
        wr(`TM2_IDX_CNTH, 32'(c[15:8]));
        wr(`TM2_IDX_MODE, 32'(mode));
        wr(`TM2_IDX_STAT, 32'hF);
    endtask

    // run for about w+4 cycles, then halt and check count and flag
    task automatic timed(input logic [7:0] mode, input logic [15:0] pair, input logic [15:0] c,
                         input logic [7:0] ctrl, input int w, input logic [15:0] e,
                         input logic [31:0] f);
        setup(mode, pair, c);
        wr(`TM2_IDX_CTRL, 32'(ctrl));
        repeat (w) @(posedge clk_i);
        wr(`TM2_IDX_CTRL, 32'h0);
        cnt_is(e);
        chk(`TM2_IDX_STAT, f, "status");
    endtask

    task automatic pulse(input int ch);
        @(posedge clk_i);
        cap[ch] <= 1'b1;
        repeat (3) @(posedge clk_i);
        cap[ch] <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // hang guard
    initial begin
        repeat (30000) @(posedge clk_i);
        miscompares++;
        final_report;
    end

    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, cap} = 59'h0;
        wstrb = 4'hF;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        foreach (regs[i]) chk(regs[i], 32'h0, "reset value");
        wr(`TM2_IDX_MODE, 32'hA5);
        chk(`TM2_IDX_MODE, 32'hA5, "mode");
        rd(`TM2_IDX_MODE, d, r, 3);
        check("mode late ready", d, 32'hA5);
        check("mode response", 32'(r), 32'(`TM2_RESP_OKAY));
        wr(8'h40, 32'h5A, `TM2_RESP_DECERR);
        rd(8'h40, d, r);
        check("unmapped data", d, 32'h0);
        check("unmapped response", 32'(r), 32'(`TM2_RESP_DECERR));
        // each divider code gives three ticks in 3.5 periods
        for (int c = 0; c < 8; c++) begin
            div = 4 << c;
            timed(8'(c << 4), 16'h0, 16'h0, 8'h04, div * 3 + div / 2 - 4, 16'h0003, 0);
        end
        timed(8'h00, 16'h0, 16'hFFFD, 8'h04, 10, 16'h0000, 1);
        chk(`TM2_IDX_CTRL, 32'h80, "flag mirror");
        check("irq masked", 32'(irq), 0);
        wr(`TM2_IDX_MASK, 32'h1);
        check("irq raised", 32'(irq), 1);
        wr(`TM2_IDX_STAT, 32'h1);
        check("irq cleared", 32'(irq), 0);
        wr(`TM2_IDX_MASK, 32'h0);
        timed(8'h80, 16'h1234, 16'hFFFF, 8'h04, 2, 16'h1234, 1);
        timed(8'h04, 16'h0002, 16'h0000, 8'h05, 10, 16'h0000, 1);
        timed(8'h00, 16'h0002, 16'h0000, 8'h05, 10, 16'h0003, 1);
        timed(8'h80, 16'h0002, 16'hFFFF, 8'h05, 2, 16'h0000, 1);
        timed(8'h80, 16'h0002, 16'h0000, 8'h04, 10, 16'h0003, 0);
        // capture channels on rising edges, reload on the chosen one only
        wr(`TM2_IDX_CAPCFG, 32'h157);
        for (int k = 1; k < 4; k++) begin
            setup(8'(8'h80 | k), 16'h1234, 16'h0005);
            pulse(k % 3);
            cnt_is(16'h0005);
            chk(8'(`TM2_IDX_CAP0 + k % 3), 32'h0005, "capture result");
            pulse(k - 1);
            cnt_is(16'h1234);
            chk(`TM2_IDX_STAT, (2 << (k % 3)) | (2 << (k - 1)), "capture flags");
        end
        setup(8'h08, 16'h0, 16'h0077);
        pulse(0);
        cnt_is(16'h0000);
        // channel 0 on falling edges, channel 2 on both, channel 1 off
        wr(`TM2_IDX_CAPCFG, 32'h205);
        setup(8'h08, 16'h0, 16'h0077);
        pulse(1);
        cnt_is(16'h0077);
        pulse(0);
        pulse(2);
        cnt_is(16'h0000);
        chk(`TM2_IDX_STAT, 32'hA, "capture flags");
        final_report;
    end
endmodule

//--- testbench/tm2_asserts.sv
`timescale 1ns/1ps
`include "tm2_defs.vh"

module tm2_asserts #(
    parameter ADDR_W = 12,
    parameter NCAP   = 3
) (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        s_axi_awvalid_i,
    input wire        s_axi_awready_o,
    input wire        s_axi_wvalid_i,
    input wire        s_axi_wready_o,
    input wire [1:0]  s_axi_bresp_o,
    input wire        s_axi_bvalid_o,
    input wire        s_axi_bready_i,
    input wire        s_axi_arvalid_i,
    input wire        s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    input wire [1:0]  s_axi_rresp_o,
    input wire        s_axi_rvalid_o,
    input wire        s_axi_rready_i,
    input wire        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // handshake steps of a register access
    sequence s_wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence

    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
        else $error("read not answered");
    a_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid_o)
        else $error("write not answered");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
        else $error("read answer dropped");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped");
    a_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while busy");
    a_write_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while busy");
    a_byte_upper: assert property (s_axi_rvalid_o && s_axi_rresp_o == `TM2_RESP_OKAY
        |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("read upper bits not zero");
    a_resp_legal: assert property (s_axi_rvalid_o |->
        s_axi_rresp_o == `TM2_RESP_OKAY || s_axi_rresp_o == `TM2_RESP_DECERR)
        else $error("bad read response");
    a_reset_idle: assert property ($rose(rstn_i) |->
        !s_axi_bvalid_o && !s_axi_rvalid_o && !irq_o)
        else $error("not idle after reset");
endmodule

bind tm2_top tm2_asserts #(.ADDR_W(ADDR_W), .NCAP(NCAP)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o));
